// ---- src/sts_defs.svh ----
`ifndef STS_DEFS_SVH
`define STS_DEFS_SVH

// --------------------------------------------------------------
// Command codes
// --------------------------------------------------------------
`define STS_CMD_SOFT_START 8'h61
`define STS_CMD_TURN_OFF 8'h64
`define STS_CMD_STATUS_BYTE 8'h78
`define STS_CMD_STATUS_WORD 8'h79

// --------------------------------------------------------------
// Reset values of the timing settings
// --------------------------------------------------------------
`define STS_SOFT_START_RST 8'h00
`define STS_TURN_OFF_RST 8'h00

// --------------------------------------------------------------
// Summary status byte bit positions
// --------------------------------------------------------------
`define STS_SB_OFF 6
`define STS_SB_OUT_OV 5
`define STS_SB_OUT_OC 4
`define STS_SB_OT 2
`define STS_SB_BUS_ERR 1
`define STS_SB_OTHER 0

// --------------------------------------------------------------
// Summary status word high-byte bit positions
// --------------------------------------------------------------
`define STS_SW_VOUT 15
`define STS_SW_IOUT 14
`define STS_SW_VIN 13
`define STS_SW_PG_N 11
`define STS_SW_OTHER 8

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define STS_CLK_PERIOD_NS 4
`define STS_MS_NS 1000000
`define STS_RISE_CODE_MAX 3'h4
`define STS_OFF_UNIT_MS 4

`endif

// ---- src/sts_pkg.sv ----
package sts_pkg;

    // Power sequencing states, gray coded along off-ramp-on-delay
    typedef enum logic [1:0] {
        STS_OFF = 2'b00,
        STS_RAMP = 2'b01,
        STS_ON = 2'b11,
        STS_DELAY = 2'b10
    } sts_state_t;

    // Command from the management bus decoder
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } sts_cmd_t;

    // Answer to a read command
    typedef struct packed {
        logic valid;
        logic word;
        logic [15:0] data;
    } sts_rsp_t;

    // Condition levels from the power stage pins
    typedef struct packed {
        logic out_ov;
        logic out_oc;
        logic out_warn;
        logic ot_warn;
        logic ot_fault;
        logic in_uv_lockout;
        logic in_ov;
        logic other;
        logic power_good;
        logic enable;
    } sts_cond_t;

endpackage

// ---- src/sts_seq_timer.sv ----
`timescale 1ns/1ps
`include "sts_defs.svh"

module sts_seq_timer import sts_pkg::*; #(
    parameter int CYC_PER_MS = `STS_MS_NS / `STS_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Settings and enable
    input wire logic enable_on,
    input wire logic [7:0] rise_code,
    input wire logic [7:0] off_delay,
    // Sequencing state
    output logic ramp_active_r,
    output logic output_on_r,
    output logic fall_start_r
);

    sts_state_t state_r, state_nxt;
    logic [31:0] cyc_r;
    logic [15:0] ms_r;
    logic ms_tick;
    logic [15:0] rise_ms;
    logic [15:0] off_ms;

    // --------------------------------------------------------------
    // Millisecond base
    // --------------------------------------------------------------
    assign ms_tick = (cyc_r == 32'(CYC_PER_MS - 1));

    // Codes at four and above all clamp to the longest ramp
    always_comb begin
        if (rise_code[2:0] >= `STS_RISE_CODE_MAX || rise_code[7:3] != 5'h0) begin
            rise_ms = 16'h0010;
        end else begin
            rise_ms = 16'h0001 << rise_code[1:0];
        end
    end

    assign off_ms = 16'(off_delay) * 16'(`STS_OFF_UNIT_MS);

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            STS_OFF: begin
                if (enable_on) begin
                    state_nxt = STS_RAMP;
                end
            end
            STS_RAMP: begin
                if (!enable_on) begin
                    state_nxt = STS_DELAY;
                end else if (ms_tick && ms_r + 16'h1 >= rise_ms) begin
                    state_nxt = STS_ON;
                end
            end
            STS_ON: begin
                if (!enable_on) begin
                    state_nxt = STS_DELAY;
                end
            end
            STS_DELAY: begin
                if (enable_on) begin
                    state_nxt = STS_ON;
                end else if (off_ms == 16'h0 || (ms_tick && ms_r + 16'h1 >= off_ms)) begin
                    state_nxt = STS_OFF;
                end
            end
            default: begin
                state_nxt = STS_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= STS_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Counters restart on every state change so each interval is whole
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cyc_r <= 32'h0;
            ms_r <= 16'h0;
        end else if (state_nxt != state_r) begin
            cyc_r <= 32'h0;
            ms_r <= 16'h0;
        end else if (ms_tick) begin
            cyc_r <= 32'h0;
            ms_r <= ms_r + 16'h1;
        end else begin
            cyc_r <= cyc_r + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ramp_active_r <= 1'b0;
            output_on_r <= 1'b0;
            fall_start_r <= 1'b0;
        end else begin
            ramp_active_r <= (state_nxt == STS_RAMP);
            output_on_r <= (state_nxt != STS_OFF);
            fall_start_r <= (state_r == STS_DELAY) && (state_nxt == STS_OFF);
        end
    end

endmodule

// ---- src/sts_regs_top.sv ----
`timescale 1ns/1ps
`include "sts_defs.svh"

// What this block does
// - Soft-start code 0..3 gives 1,2,4,8 ms; codes 4 and up give 16 ms.
// - Soft-start time runs from output start of rise to regulation.
// - Turn-off delay counts 4 ms units up to FFh, enable off to fall.
// - Status byte is answered as a single byte to a read-byte request.
// - Latched flags clear only after cause ends and then fault-clear arrives.
// - Status byte bits 7,3 and word bits 12,10,9 always read zero.
// - Byte bit 6 is live: one while converter disabled by input or command.
// - Byte bit 5 latches on output overvoltage fault.
// - Byte bit 4 latches on output overcurrent fault.
// - Byte bit 2 latches on overtemperature warning or fault.
// - Byte bit 1 latches on any management bus communication error.
// - Byte bit 0 latches on an event no other byte bit covers.
// - Word bit 15 latches on any output voltage fault or warning.
// - Word bit 14 latches on any output current fault.
// - Word bit 13 reads one until input passes lockout, also input faults.
// - Word bit 11 is live inverted power-good.
// - Word bit 8 latches on a fault no other word bit covers.
// - Word low byte equals the status byte.
// - Overtemperature warning sets both summaries and asserts the alert output.
module sts_regs_top import sts_pkg::*; #(
    parameter int CYC_PER_MS = `STS_MS_NS / `STS_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Command port from the management bus decoder
    input wire sts_cmd_t cmd,
    input wire logic clear_faults,
    input wire logic bus_error,
    input wire logic op_off,
    output sts_rsp_t rsp_r,
    // Condition pins from the power stage
    input wire sts_cond_t cond_pins,
    // Alert and sequencing
    output logic alert_output_n_r,
    output logic ramp_active_r,
    output logic output_on_r,
    output logic fall_start_r
);

    localparam int NCOND = $bits(sts_cond_t);

    sts_cond_t sync1_r, sync2_r;
    logic [7:0] soft_start_time_r;
    logic [7:0] turn_off_delay_r;
    logic output_overvoltage_flag_r;
    logic output_overcurrent_flag_r;
    logic overtemperature_flag_r;
    logic bus_error_flag_r;
    logic other_event_flag_r;
    logic vout_summary_r;
    logic output_current_summary_r;
    logic input_fault_r;
    logic unknown_word_r;
    logic bad_cmd;
    logic clr_ok_cmd;
    logic converter_off;
    logic [7:0] status_byte;
    logic [15:0] status_word;

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    // Condition pins are asynchronous to clk, each bit gets two flops
    genvar gi;
    generate
        for (gi = 0; gi < NCOND; gi++) begin : g_sync
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= cond_pins[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    // --------------------------------------------------------------
    // Command decode
    // --------------------------------------------------------------
    // Writes to read-only codes and any command to an unknown code count as bus errors
    always_comb begin
        bad_cmd = 1'b0;
        if (cmd.valid) begin
            case (cmd.code)
                `STS_CMD_SOFT_START: bad_cmd = 1'b0;
                `STS_CMD_TURN_OFF: bad_cmd = 1'b0;
                `STS_CMD_STATUS_BYTE: bad_cmd = cmd.write;
                `STS_CMD_STATUS_WORD: bad_cmd = cmd.write;
                default: bad_cmd = 1'b1;
            endcase
        end
    end

    assign clr_ok_cmd = clear_faults;

    // --------------------------------------------------------------
    // Timing settings
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            soft_start_time_r <= `STS_SOFT_START_RST;
        end else if (cmd.valid && cmd.write && cmd.code == `STS_CMD_SOFT_START) begin
            soft_start_time_r <= cmd.wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            turn_off_delay_r <= `STS_TURN_OFF_RST;
        end else if (cmd.valid && cmd.write && cmd.code == `STS_CMD_TURN_OFF) begin
            turn_off_delay_r <= cmd.wdata[7:0];
        end
    end

    // --------------------------------------------------------------
    // Latched flags
    // --------------------------------------------------------------
    // Set wins over clear; a clear only acts once the cause is gone
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            output_overvoltage_flag_r <= 1'b0;
        end else if (sync2_r.out_ov) begin
            output_overvoltage_flag_r <= 1'b1;
        end else if (clr_ok_cmd) begin
            output_overvoltage_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            output_overcurrent_flag_r <= 1'b0;
        end else if (sync2_r.out_oc) begin
            output_overcurrent_flag_r <= 1'b1;
        end else if (clr_ok_cmd) begin
            output_overcurrent_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            overtemperature_flag_r <= 1'b0;
        end else if (sync2_r.ot_warn || sync2_r.ot_fault) begin
            overtemperature_flag_r <= 1'b1;
        end else if (clr_ok_cmd) begin
            overtemperature_flag_r <= 1'b0;
        end
    end

    // A bus error is an event, so its cause is gone once it has been seen
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_error_flag_r <= 1'b0;
        end else if (bus_error || bad_cmd) begin
            bus_error_flag_r <= 1'b1;
        end else if (clr_ok_cmd) begin
            bus_error_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            other_event_flag_r <= 1'b0;
        end else if (sync2_r.other || sync2_r.out_warn || sync2_r.in_ov) begin
            other_event_flag_r <= 1'b1;
        end else if (clr_ok_cmd) begin
            other_event_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vout_summary_r <= 1'b0;
        end else if (sync2_r.out_ov || sync2_r.out_warn) begin
            vout_summary_r <= 1'b1;
        end else if (clr_ok_cmd) begin
            vout_summary_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            output_current_summary_r <= 1'b0;
        end else if (sync2_r.out_oc) begin
            output_current_summary_r <= 1'b1;
        end else if (clr_ok_cmd) begin
            output_current_summary_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            input_fault_r <= 1'b0;
        end else if (sync2_r.in_ov) begin
            input_fault_r <= 1'b1;
        end else if (clr_ok_cmd) begin
            input_fault_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            unknown_word_r <= 1'b0;
        end else if (sync2_r.other) begin
            unknown_word_r <= 1'b1;
        end else if (clr_ok_cmd) begin
            unknown_word_r <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Status assembly
    // --------------------------------------------------------------
    assign converter_off = sync2_r.in_uv_lockout || sync2_r.in_ov || op_off;

    always_comb begin
        status_byte = 8'h00;
        status_byte[`STS_SB_OFF] = converter_off;
        status_byte[`STS_SB_OUT_OV] = output_overvoltage_flag_r;
        status_byte[`STS_SB_OUT_OC] = output_overcurrent_flag_r;
        status_byte[`STS_SB_OT] = overtemperature_flag_r;
        status_byte[`STS_SB_BUS_ERR] = bus_error_flag_r;
        status_byte[`STS_SB_OTHER] = other_event_flag_r;
    end

    always_comb begin
        status_word = {8'h00, status_byte};
        status_word[`STS_SW_VOUT] = vout_summary_r;
        status_word[`STS_SW_IOUT] = output_current_summary_r;
        // Live during start-up below lockout, latched for input faults
        status_word[`STS_SW_VIN] = input_fault_r || sync2_r.in_uv_lockout;
        status_word[`STS_SW_PG_N] = !sync2_r.power_good;
        status_word[`STS_SW_OTHER] = unknown_word_r;
    end

    // --------------------------------------------------------------
    // Read answer
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rsp_r <= '0;
        end else begin
            rsp_r.valid <= cmd.valid && !cmd.write && !bad_cmd;
            rsp_r.word <= 1'b1;
            rsp_r.data <= 16'h0000;
            case (cmd.code)
                `STS_CMD_SOFT_START: rsp_r.data <= {8'h00, soft_start_time_r};
                `STS_CMD_TURN_OFF: rsp_r.data <= {8'h00, turn_off_delay_r};
                `STS_CMD_STATUS_BYTE: begin
                    rsp_r.word <= 1'b0;
                    rsp_r.data <= {8'h00, status_byte};
                end
                `STS_CMD_STATUS_WORD: rsp_r.data <= status_word;
                default: rsp_r.data <= 16'h0000;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Alert
    // --------------------------------------------------------------
    // Alert follows the latched warning flags, so it drops with the clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alert_output_n_r <= 1'b1;
        end else begin
            alert_output_n_r <= !(overtemperature_flag_r || output_overvoltage_flag_r ||
                output_overcurrent_flag_r || bus_error_flag_r || other_event_flag_r);
        end
    end

    // --------------------------------------------------------------
    // Sequencing timer
    // --------------------------------------------------------------
    sts_seq_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_seq (
        .clk(clk),
        .resetn(resetn),
        .enable_on(sync2_r.enable && !op_off),
        .rise_code(soft_start_time_r),
        .off_delay(turn_off_delay_r),
        .ramp_active_r(ramp_active_r),
        .output_on_r(output_on_r),
        .fall_start_r(fall_start_r)
    );

endmodule

// ---- testbench/sts_regs_top_properties.sv ----
`timescale 1ns/1ps
`include "sts_defs.svh"

module sts_regs_checker import sts_pkg::*; #(
    parameter int CYC_PER_MS = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Command side
    input wire sts_cmd_t cmd,
    input wire logic clear_faults,
    input wire logic bus_error,
    input wire logic op_off,
    input wire sts_rsp_t rsp_r,
    // Power stage side
    input wire sts_cond_t cond_pins,
    input wire logic alert_output_n_r,
    input wire logic ramp_active_r,
    input wire logic output_on_r,
    input wire logic fall_start_r
);
    logic [15:0] ramp_cnt_r;
    logic rd_ok;

    assign rd_ok = cmd.valid && !cmd.write && (cmd.code inside {`STS_CMD_SOFT_START,
        `STS_CMD_TURN_OFF, `STS_CMD_STATUS_BYTE, `STS_CMD_STATUS_WORD});

    // Ramp length counter, cleared whenever the ramp is not running
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ramp_cnt_r <= 16'h0000;
        end else if (ramp_active_r) begin
            ramp_cnt_r <= ramp_cnt_r + 16'h0001;
        end else begin
            ramp_cnt_r <= 16'h0000;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_read_answer: assert property (rd_ok |=> rsp_r.valid)
        else $error("read command got no answer");
    chk_write_silent: assert property (cmd.valid && cmd.write |=> !rsp_r.valid)
        else $error("write command got an answer");
    chk_byte_zeros: assert property (rsp_r.valid && !rsp_r.word
        |-> rsp_r.data[15:8] == 8'h00 && !rsp_r.data[7] && !rsp_r.data[3])
        else $error("status byte reserved bits not zero");
    chk_word_zeros: assert property (rsp_r.valid && $past(cmd.code) == 8'h79
        |-> !rsp_r.data[12] && rsp_r.data[10:9] == 2'b00)
        else $error("status word reserved bits not zero");
    chk_off_live: assert property (op_off[*4] ##0
        (rsp_r.valid && $past(cmd.code) == 8'h78) |-> rsp_r.data[6])
        else $error("off flag clear while operation off");
    chk_pg_live: assert property (cond_pins.power_good[*7] ##0
        (rsp_r.valid && $past(cmd.code) == 8'h79) |-> !rsp_r.data[11])
        else $error("power good flag wrong");
    chk_ot_alert: assert property (cond_pins.ot_warn[*7] |-> !alert_output_n_r)
        else $error("alert not asserted on temperature warning");
    chk_fall_pulse: assert property (fall_start_r |-> !output_on_r ##1 !fall_start_r)
        else $error("fall start not a single pulse into off");
    chk_ramp_upper: assert property (ramp_cnt_r <= 16'(16 * CYC_PER_MS + 1))
        else $error("ramp longer than the longest soft start");
    // Only a ramp that ran to its end, not one cut by enable going away
    chk_ramp_lower: assert property ($fell(ramp_active_r) && $past(resetn)
        && $past(cond_pins.enable, 3) && !$past(op_off)
        |-> ramp_cnt_r >= 16'(CYC_PER_MS) && output_on_r)
        else $error("ramp shorter than one ms or not on");
endmodule

bind sts_regs_top sts_regs_checker #(.CYC_PER_MS(CYC_PER_MS)) u_sts_regs_checker (
    .clk(clk), .resetn(resetn), .cmd(cmd), .clear_faults(clear_faults),
    .bus_error(bus_error), .op_off(op_off), .rsp_r(rsp_r), .cond_pins(cond_pins),
    .alert_output_n_r(alert_output_n_r), .ramp_active_r(ramp_active_r),
    .output_on_r(output_on_r), .fall_start_r(fall_start_r));

// ---- testbench/sts_host_model.sv ----
`timescale 1ns/1ps

module sts_host_model import sts_pkg::*; (
    // Clock and answer
    input wire logic clk,
    input wire sts_rsp_t rsp_r,
    // Requests to the block
    output sts_cmd_t cmd,
    output logic clear_faults,
    output logic bus_error
);
    initial begin
        cmd = '0;
        clear_faults = 1'b0;
        bus_error = 1'b0;
    end

    // One command, held across exactly one rising edge
    task automatic send(input logic w, input logic [7:0] code, input logic [15:0] d);
        @(negedge clk);
        cmd = '{valid: 1'b1, write: w, code: code, wdata: d};
        @(negedge clk);
        cmd.valid = 1'b0;
    endtask

    // Read-byte or read-word, waiting a few cycles for the answer
    task automatic read(input logic [7:0] code, output logic [15:0] d, output logic w,
        output logic ok);
        ok = 1'b0;
        d = 16'h0000;
        w = 1'b0;
        send(1'b0, code, 16'h0000);
        for (int k = 0; k < 4 && !ok; k++) begin
            if (rsp_r.valid === 1'b1) begin
                ok = 1'b1;
                d = rsp_r.data;
                w = rsp_r.word;
            end else begin
                @(negedge clk);
            end
        end
    endtask

    // Fault-clear (sel 0) or bus error event (sel 1), one cycle wide
    task automatic pulse(input logic sel);
        @(negedge clk);
        if (sel) bus_error = 1'b1;
        else clear_faults = 1'b1;
        @(negedge clk);
        bus_error = 1'b0;
        clear_faults = 1'b0;
    endtask
endmodule

// ---- testbench/sts_regs_top_tb.sv ----
`timescale 1ns/1ps
`include "sts_defs.svh"

module sts_regs_top_tb;
    import sts_pkg::*;
    localparam int C = 4;
    localparam logic [7:0] c_rise = `STS_CMD_SOFT_START;
    localparam logic [7:0] c_off = `STS_CMD_TURN_OFF;
    localparam logic [7:0] c_byte = `STS_CMD_STATUS_BYTE;
    localparam logic [7:0] c_word = `STS_CMD_STATUS_WORD;
    logic clk, resetn, op_off, clear_faults, bus_error, alert_n, ramp, on, fall;
    sts_cond_t cond;
    sts_cmd_t cmd;
    sts_rsp_t rsp;
    logic [2:0] mon;
    int err_count, checked;

    assign mon = {on, fall, ramp};

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    sts_regs_top #(.CYC_PER_MS(C)) u_sts_regs_top (.clk(clk), .resetn(resetn), .cmd(cmd),
        .clear_faults(clear_faults), .bus_error(bus_error), .op_off(op_off), .rsp_r(rsp),
        .cond_pins(cond), .alert_output_n_r(alert_n), .ramp_active_r(ramp),
        .output_on_r(on), .fall_start_r(fall));
    sts_host_model u_sts_host_model (.clk(clk), .rsp_r(rsp), .cmd(cmd),
        .clear_faults(clear_faults), .bus_error(bus_error));

    // ----------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------
    task automatic results;
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wait_lvl(input int b, input logic v, input int lim, output int n);
        n = 0;
        while (mon[b] !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (mon[b] !== v) begin
            err_count++;
            $display("MISMATCH sequencer output %0d expected %b seen %b", b, v, mon[b]);
            results();
        end
    endtask

    task automatic wr(input logic [7:0] code, input logic [15:0] d);
        u_sts_host_model.send(1'b1, code, d);
    endtask

    task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic wexp);
        logic [15:0] d;
        logic w;
        logic ok;
        u_sts_host_model.read(code, d, w, ok);
        chk("answer", 16'h0001, {15'h0, ok});
        chk("read data", exp, d);
        chk("word flag", {15'h0, wexp}, {15'h0, w});
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reset;
        rd(c_rise, 16'h0000, 1'b1);
        rd(c_off, 16'h0000, 1'b1);
        rd(c_byte, 16'h0000, 1'b0);
        rd(c_word, 16'h0000, 1'b1);
        wr(c_rise, 16'hff03);
        rd(c_rise, 16'h0003, 1'b1);
        wr(c_off, 16'h12ff);
        rd(c_off, 16'h00ff, 1'b1);
    endtask

    task automatic t_soft;
        logic [7:0] codes [6];
        int n;
        int ms;
        codes = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07};
        wr(c_off, 16'h0000);
        foreach (codes[i]) begin
            wr(c_rise, {8'h00, codes[i]});
            ms = (codes[i] < 8'h04) ? (1 << codes[i]) : 16;
            cond.enable = 1'b1;
            wait_lvl(0, 1'b1, 20, n);
            wait_lvl(0, 1'b0, 80, n);
            chk("ramp cycles", 16'(ms * C), 16'((n == ms * C + 1) ? ms * C : n));
            chk("on after ramp", 16'h0001, {15'h0, on});
            cond.enable = 1'b0;
            wait_lvl(1, 1'b1, 10, n);
            idle(2);
            chk("off after fall", 16'h0000, {15'h0, on});
        end
    endtask

    task automatic t_off;
        int n;
        wr(c_rise, 16'h0000);
        wr(c_off, 16'h0002);
        cond.enable = 1'b1;
        wait_lvl(0, 1'b1, 20, n);
        wait_lvl(0, 1'b0, 20, n);
        // Re-enable well inside the 8 ms delay: the output must not fall
        cond.enable = 1'b0;
        idle(10);
        cond.enable = 1'b1;
        idle(40);
        chk("stays on", 16'h0001, {15'h0, on});
        cond.enable = 1'b0;
        wait_lvl(1, 1'b1, 60, n);
        chk("off delay", 16'd32, 16'((n >= 32 && n <= 36) ? 32 : n));
    endtask

    task automatic t_latch;
        logic [9:0] cm [6];
        logic [15:0] ew [6];
        cm = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020, 10'h004};
        ew = '{16'h8020, 16'h4010, 16'h8001, 16'h0004, 16'h0004, 16'h0101};
        foreach (cm[i]) begin
            cond = sts_cond_t'(10'h002 | cm[i]);
            idle(6);
            rd(c_byte, {8'h00, ew[i][7:0]}, 1'b0);
            rd(c_word, ew[i], 1'b1);
            chk("alert", 16'h0000, {15'h0, alert_n});
            u_sts_host_model.pulse(1'b0);
            idle(2);
            rd(c_word, ew[i], 1'b1);
            cond = sts_cond_t'(10'h002);
            idle(6);
            rd(c_word, ew[i], 1'b1);
            u_sts_host_model.pulse(1'b0);
            idle(2);
            rd(c_word, 16'h0000, 1'b1);
            chk("alert", 16'h0001, {15'h0, alert_n});
        end
    endtask

    task automatic t_live;
        op_off = 1'b1;
        idle(5);
        rd(c_byte, 16'h0040, 1'b0);
        op_off = 1'b0;
        cond = sts_cond_t'(10'h012);
        idle(5);
        rd(c_word, 16'h2040, 1'b1);
        cond = sts_cond_t'(10'h002);
        idle(5);
        rd(c_word, 16'h0000, 1'b1);
        cond = sts_cond_t'(10'h008);
        idle(5);
        rd(c_word, 16'h2841, 1'b1);
        cond = sts_cond_t'(10'h002);
        idle(5);
        rd(c_word, 16'h2001, 1'b1);
        u_sts_host_model.pulse(1'b0);
    endtask

    task automatic t_bus;
        logic [15:0] d;
        logic w;
        logic ok;
        u_sts_host_model.pulse(1'b1);
        idle(2);
        rd(c_byte, 16'h0002, 1'b0);
        u_sts_host_model.pulse(1'b0);
        idle(1);
        rd(c_byte, 16'h0000, 1'b0);
        u_sts_host_model.read(8'h50, d, w, ok);
        chk("unmapped answer", 16'h0000, {15'h0, ok});
        wr(c_byte, 16'h00ff);
        idle(2);
        rd(c_word, 16'h0002, 1'b1);
        u_sts_host_model.pulse(1'b0);
        idle(1);
    endtask

    initial begin
        resetn = 1'b0;
        op_off = 1'b0;
        cond = sts_cond_t'(10'h002);
        err_count = 0;
        checked = 0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        idle(6);
        t_reset();
        t_soft();
        t_off();
        t_latch();
        t_live();
        t_bus();
        results();
    end
endmodule
